// *** pkg/scc_consts.svh ***
// constants for the reference capture control block: offsets, fields, resets
// assumes a 32-bit apb slave with one register per aligned word
//
// Overview of operation
// - flag reset bit holds setup/hold flags cleared
// - transition select: 0 rising, 1 falling valid
// - edge select: sample on rising or falling clock
// - mode field: disabled, continuous, one-shot
// - one-shot skips first N valid transitions
// - negative skew window of 0 to 3 clocks
// - positive skew window, 00 means none
// - positive values 01..11 give one to three clocks
`ifndef SCC_CONSTS_SVH
`define SCC_CONSTS_SVH

// register indices; byte address is four times the index
`define SCC_IDX_CTRL        12'h0120
`define SCC_IDX_IGNORE      12'h0121
`define SCC_IDX_SKEW        12'h0122
`define SCC_IDX_IRQ_STATUS  12'h0130
`define SCC_IDX_IRQ_MASK    12'h0131
`define SCC_IDX_STATE       12'h0132

// control register fields
`define SCC_CTRL_FLAGRST    6
`define SCC_CTRL_TRANSSEL   4
`define SCC_CTRL_EDGESEL    3
`define SCC_CTRL_MODE_HI    2
`define SCC_CTRL_MODE_LO    1
`define SCC_IGN_HI          3
`define SCC_SKEW_NEG_HI     3
`define SCC_SKEW_NEG_LO     2
`define SCC_SKEW_POS_HI     1

// interrupt status bits
`define SCC_IRQ_REALIGN     0
`define SCC_IRQ_SETUP       1
`define SCC_IRQ_HOLD        2
`define SCC_IRQ_DONE        3
`define SCC_IRQ_W           4

`define SCC_RESET_VALUE     8'h00
`define SCC_FRAME_PERIOD    16

`endif

// *** pkg/scc_pkg.sv ***
// types shared by the reference capture control block
// assumes scc_consts.svh supplies the numeric constants
`default_nettype none
package scc_pkg;

  // capture mode field, in field value order
  typedef enum logic [1:0] {
    SCC_MODE_OFF,
    SCC_MODE_CONT,
    SCC_MODE_ONESHOT,
    SCC_MODE_RSVD
  } scc_mode_t;

  // skew window settings, each 0 to 3 sample clocks
  typedef struct packed {
    logic [1:0] neg;
    logic [1:0] pos;
  } scc_win_t;

  // classification of the current phase against the windows
  typedef struct packed {
    logic aligned;
    logic early;
    logic late;
  } scc_class_t;

endpackage
`default_nettype wire

// *** rtl/scc_ref_sampler.sv ***
// samples the reference pin on either clock edge and synchronises it
// assumes refPin is asynchronous to clk
`timescale 1ns/1ps
`default_nettype none
module scc_ref_sampler (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // pin and control
  input  wire logic refPin,
  input  wire logic edgeSel,
  // synchronised level
  output logic      refLevel
);
  import scc_pkg::*;

  logic riseMeta_ff, riseSync_ff;
  logic fallMeta_ff, fallSync_ff;
  logic refLevel_ff;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      riseMeta_ff <= 1'b0;
      riseSync_ff <= 1'b0;
    end else begin
      riseMeta_ff <= refPin;
      riseSync_ff <= riseMeta_ff;
    end
  end

  // falling-edge chain; its output is read half a cycle later
  always_ff @(negedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fallMeta_ff <= 1'b0;
      fallSync_ff <= 1'b0;
    end else begin
      fallMeta_ff <= refPin;
      fallSync_ff <= fallMeta_ff;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) refLevel_ff <= 1'b0;
    else        refLevel_ff <= edgeSel ? fallSync_ff : riseSync_ff;
  end

  assign refLevel = refLevel_ff;

endmodule
`default_nettype wire

// *** rtl/scc_window_check.sv ***
// classifies the frame phase against the negative and positive windows
// assumes phase 0 is the expected capture clock
`timescale 1ns/1ps
`default_nettype none
`include "scc_consts.svh"
module scc_window_check #(
  parameter int PERIOD = `SCC_FRAME_PERIOD,
  parameter int PW     = $clog2(PERIOD)
) (
  // inputs
  input  wire logic [PW-1:0]     phase,
  input  wire scc_pkg::scc_win_t win,
  // result
  output scc_pkg::scc_class_t    cls
);
  import scc_pkg::*;

  // one bit wider than the phase, so a power-of-two period does not wrap
  localparam logic [PW:0] PER  = (PW+1)'(PERIOD);
  localparam logic [PW:0] HALF = (PW+1)'(PERIOD / 2);

  logic [PW:0] ph;
  logic        earlyIn;
  logic        lateIn;

  always_comb begin
    ph      = {1'b0, phase};
    earlyIn = (win.neg != 2'b00) && (ph >= PER - (PW+1)'(win.neg));
    lateIn  = (ph != '0) && (ph <= (PW+1)'(win.pos));
    cls.aligned = (ph == '0) || earlyIn || lateIn;
    cls.early   = !cls.aligned && (ph >= HALF);
    cls.late    = !cls.aligned && (ph < HALF);
  end

endmodule
`default_nettype wire

// *** rtl/scc_capture_ctrl.sv ***
// reference capture control: apb registers, qualification, realign
// assumes a zero-wait apb master on clk and an asynchronous reference pin
//
// The implementer's own choice: register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "scc_consts.svh"
module scc_capture_ctrl #(
  parameter int PERIOD = `SCC_FRAME_PERIOD
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // reference pin
  input  wire logic        refPin,
  // results
  output logic             realign,
  output logic             setupErr,
  output logic             holdErr,
  output logic             irq
);
  import scc_pkg::*;

  localparam int PW = $clog2(PERIOD);

  typedef enum logic [2:0] {
    SCC_SEL_CTRL,
    SCC_SEL_IGNORE,
    SCC_SEL_SKEW,
    SCC_SEL_STATUS,
    SCC_SEL_MASK,
    SCC_SEL_STATE,
    SCC_SEL_NONE
  } scc_sel_t;

  function automatic scc_sel_t decode(input logic [31:0] addr);
    if (addr[1:0] != 2'b00 || addr[31:14] != '0) return SCC_SEL_NONE;
    case (addr[13:2])
      `SCC_IDX_CTRL:       return SCC_SEL_CTRL;
      `SCC_IDX_IGNORE:     return SCC_SEL_IGNORE;
      `SCC_IDX_SKEW:       return SCC_SEL_SKEW;
      `SCC_IDX_IRQ_STATUS: return SCC_SEL_STATUS;
      `SCC_IDX_IRQ_MASK:   return SCC_SEL_MASK;
      `SCC_IDX_STATE:      return SCC_SEL_STATE;
      default:             return SCC_SEL_NONE;
    endcase
  endfunction

  // configuration
  logic                  flagReset_ff;
  logic                  transSel_ff;
  logic                  edgeSel_ff;
  logic [1:0]            mode_ff;
  logic [3:0]            ignoreCnt_ff;
  scc_win_t              win_ff;
  logic [`SCC_IRQ_W-1:0] irqStatus_ff;
  logic [`SCC_IRQ_W-1:0] irqMask_ff;
  // datapath state
  logic                  prevLevel_ff;
  logic [PW-1:0]         phase_ff;
  logic                  armed_ff;
  logic [3:0]            remain_ff;
  logic                  setupFlag_ff;
  logic                  holdFlag_ff;
  logic                  realign_ff;
  logic [31:0]           prdata_ff;
  // combinational
  scc_sel_t              sel;
  logic                  wrEn;
  logic                  rdSetup;
  logic                  ctrlWrite;
  logic                  refLevel;
  logic                  rise;
  logic                  fall;
  logic                  valid;
  scc_mode_t             mode;
  scc_class_t            cls;
  logic                  act;
  logic                  oneshotHit;
  logic                  capOn;
  logic [`SCC_IRQ_W-1:0] irqEvents;
  logic [31:0]           nxt_prdata;
  logic [PW-1:0]         nxt_phase;

  // bus decode: zero wait states, unmapped addresses answer with an error
  assign sel       = decode(paddr);
  assign pready    = 1'b1;
  assign pslverr   = psel && penable && (sel == SCC_SEL_NONE);
  assign wrEn      = psel && penable && pwrite && (sel != SCC_SEL_NONE);
  assign rdSetup   = psel && !penable && !pwrite;
  assign ctrlWrite = wrEn && (sel == SCC_SEL_CTRL);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flagReset_ff <= 1'b0;
      transSel_ff  <= 1'b0;
      edgeSel_ff   <= 1'b0;
      mode_ff      <= 2'b00;
    end else if (ctrlWrite) begin
      flagReset_ff <= pwdata[`SCC_CTRL_FLAGRST];
      transSel_ff  <= pwdata[`SCC_CTRL_TRANSSEL];
      edgeSel_ff   <= pwdata[`SCC_CTRL_EDGESEL];
      mode_ff      <= pwdata[`SCC_CTRL_MODE_HI:`SCC_CTRL_MODE_LO];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ignoreCnt_ff <= 4'h0;
      win_ff       <= '0;
      irqMask_ff   <= '0;
    end else if (wrEn) begin
      case (sel)
        SCC_SEL_IGNORE: ignoreCnt_ff <= pwdata[`SCC_IGN_HI:0];
        SCC_SEL_SKEW: begin
          win_ff.neg <= pwdata[`SCC_SKEW_NEG_HI:`SCC_SKEW_NEG_LO];
          win_ff.pos <= pwdata[`SCC_SKEW_POS_HI:0];
        end
        SCC_SEL_MASK: irqMask_ff <= pwdata[`SCC_IRQ_W-1:0];
        default: ;
      endcase
    end
  end

  // reference sampling and transition detection
  scc_ref_sampler u_sampler (
    .clk      (clk),
    .rst_n    (rst_n),
    .refPin   (refPin),
    .edgeSel  (edgeSel_ff),
    .refLevel (refLevel)
  );

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) prevLevel_ff <= 1'b0;
    else        prevLevel_ff <= refLevel;
  end

  assign rise  = refLevel && !prevLevel_ff;
  assign fall  = !refLevel && prevLevel_ff;
  assign valid = transSel_ff ? fall : rise;
  assign mode  = scc_mode_t'(mode_ff);
  // the reserved mode code behaves as disabled, flags included
  assign capOn = (mode == SCC_MODE_CONT)
                 || (mode == SCC_MODE_ONESHOT);

  // frame phase; phase 0 is the expected capture clock
  scc_window_check #(
    .PERIOD (PERIOD),
    .PW     (PW)
  ) u_window (
    .phase (phase_ff),
    .win   (win_ff),
    .cls   (cls)
  );

  // one-shot acts only when the ignore count has run out
  assign oneshotHit = (mode == SCC_MODE_ONESHOT) && armed_ff
                      && (remain_ff == 4'h0);

  always_comb begin
    act = 1'b0;
    case (mode)
      SCC_MODE_OFF:     act = 1'b0;
      SCC_MODE_CONT:    act = valid && !cls.aligned;
      SCC_MODE_ONESHOT: act = valid && oneshotHit && !cls.aligned;
      default:          act = 1'b0;
    endcase
  end

  always_comb begin
    if (act)                      nxt_phase = PW'(1);
    else if (phase_ff == PW'(PERIOD - 1)) nxt_phase = '0;
    else                          nxt_phase = phase_ff + PW'(1);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) phase_ff <= '0;
    else        phase_ff <= nxt_phase;
  end

  // one-shot arming; rewriting the mode re-arms, qualifying edges count down the ignore count, then one disarms
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      armed_ff  <= 1'b0;
      remain_ff <= 4'h0;
    end else if (ctrlWrite) begin
      armed_ff  <= (pwdata[`SCC_CTRL_MODE_HI:`SCC_CTRL_MODE_LO]
                    == 2'(SCC_MODE_ONESHOT));
      remain_ff <= ignoreCnt_ff;
    end else if (valid && mode == SCC_MODE_ONESHOT && armed_ff) begin
      if (remain_ff == 4'h0) armed_ff <= 1'b0;
      else                   remain_ff <= remain_ff - 4'h1;
    end
  end

  // setup/hold flags; the reset bit wins over a new error
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      setupFlag_ff <= 1'b0;
      holdFlag_ff  <= 1'b0;
    end else if (flagReset_ff) begin
      setupFlag_ff <= 1'b0;
      holdFlag_ff  <= 1'b0;
    end else if (valid && capOn) begin
      setupFlag_ff <= setupFlag_ff || cls.early;
      holdFlag_ff  <= holdFlag_ff || cls.late;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) realign_ff <= 1'b0;
    else        realign_ff <= act;
  end

  // sticky interrupt status, write one to clear, a new event wins
  assign irqEvents[`SCC_IRQ_REALIGN] = act;
  assign irqEvents[`SCC_IRQ_SETUP]   = valid && cls.early && !flagReset_ff
                                       && capOn;
  assign irqEvents[`SCC_IRQ_HOLD]    = valid && cls.late && !flagReset_ff
                                       && capOn;
  assign irqEvents[`SCC_IRQ_DONE]    = valid && oneshotHit;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irqStatus_ff <= '0;
    end else begin
      irqStatus_ff <= irqEvents | (irqStatus_ff
        & ~((wrEn && sel == SCC_SEL_STATUS) ? pwdata[`SCC_IRQ_W-1:0] : '0));
    end
  end

  // read data is latched in the setup phase so it is stable in access
  always_comb begin
    nxt_prdata = 32'h0000_0000;
    case (sel)
      SCC_SEL_CTRL: begin
        nxt_prdata[`SCC_CTRL_FLAGRST]  = flagReset_ff;
        nxt_prdata[`SCC_CTRL_TRANSSEL] = transSel_ff;
        nxt_prdata[`SCC_CTRL_EDGESEL]  = edgeSel_ff;
        nxt_prdata[`SCC_CTRL_MODE_HI:`SCC_CTRL_MODE_LO] = mode_ff;
      end
      SCC_SEL_IGNORE: nxt_prdata[`SCC_IGN_HI:0] = ignoreCnt_ff;
      SCC_SEL_SKEW: begin
        nxt_prdata[`SCC_SKEW_NEG_HI:`SCC_SKEW_NEG_LO] = win_ff.neg;
        nxt_prdata[`SCC_SKEW_POS_HI:0] = win_ff.pos;
      end
      SCC_SEL_STATUS: nxt_prdata[`SCC_IRQ_W-1:0] = irqStatus_ff;
      SCC_SEL_MASK:   nxt_prdata[`SCC_IRQ_W-1:0] = irqMask_ff;
      SCC_SEL_STATE: begin
        nxt_prdata[0]    = setupFlag_ff;
        nxt_prdata[1]    = holdFlag_ff;
        nxt_prdata[2]    = armed_ff;
        nxt_prdata[7:4]  = remain_ff;
        nxt_prdata[8+:PW] = phase_ff;
      end
      default: nxt_prdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)       prdata_ff <= 32'h0000_0000;
    else if (rdSetup) prdata_ff <= nxt_prdata;
  end

  assign prdata   = prdata_ff;
  assign realign  = realign_ff;
  assign setupErr = setupFlag_ff;
  assign holdErr  = holdFlag_ff;
  assign irq      = |(irqStatus_ff & irqMask_ff);

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_arm_write;
    ctrlWrite && pwdata[`SCC_CTRL_MODE_HI:`SCC_CTRL_MODE_LO]
      == 2'(SCC_MODE_ONESHOT);
  endsequence

  sequence s_armed_with_count;
    armed_ff && remain_ff == $past(ignoreCnt_ff);
  endsequence

  AST_FLAG_RESET: assert property (
    flagReset_ff |=> !setupFlag_ff && !holdFlag_ff)
    else $error("setup/hold flag set while flag reset held");

  AST_TRANS_SEL: assert property (
    act |-> (transSel_ff ? (prevLevel_ff && !refLevel)
                         : (!prevLevel_ff && refLevel)))
    else $error("realign on a transition of the wrong direction");

  AST_MODE_OFF: assert property (
    !capOn |=> !realign_ff)
    else $error("realign while capture disabled");

  AST_OFF_FLAGS: assert property (
    !capOn && !setupFlag_ff && !holdFlag_ff
      |=> !setupFlag_ff && !holdFlag_ff)
    else $error("setup/hold flag set while capture disabled");

  AST_ONESHOT_ARM: assert property (
    s_arm_write |=> s_armed_with_count)
    else $error("one-shot not armed with the ignore count");

  AST_ONESHOT_SKIP: assert property (
    act && mode == SCC_MODE_ONESHOT |-> remain_ff == 4'h0 && armed_ff)
    else $error("one-shot acted before the ignore count ran out");

  AST_NEG_WIN: assert property (
    valid && win_ff.neg != 2'b00
      && {1'b0, phase_ff} >= (PW+1)'(PERIOD) - (PW+1)'(win_ff.neg)
      |-> !act)
    else $error("realign inside the negative skew window");

  AST_POS_WIN: assert property (
    valid && phase_ff != '0 && {{(PW-2){1'b0}}, win_ff.pos} >= phase_ff
      |-> !act)
    else $error("realign inside the positive skew window");

  AST_POS_EXACT: assert property (
    valid && mode == SCC_MODE_CONT && win_ff.pos == 2'b01
      && phase_ff == PW'(2) |-> act ##1 realign_ff)
    else $error("one clock positive skew did not bound the window");

  AST_CONT: assert property (
    valid && mode == SCC_MODE_CONT && !cls.aligned |=> realign_ff
      ##1 phase_ff == PW'(2))
    else $error("continuous mode missed a realign");

  AST_ONESHOT_ONCE: assert property (
    act && mode == SCC_MODE_ONESHOT && !ctrlWrite
      |=> !armed_ff ##1 (!armed_ff || $past(ctrlWrite)))
    else $error("one-shot rearmed without a mode write");

  AST_IRQ: assert property (
    irqStatus_ff[`SCC_IRQ_REALIGN] && irqMask_ff[`SCC_IRQ_REALIGN]
      |-> irq)
    else $error("masked-in status bit did not raise the interrupt");

endmodule
`default_nettype wire

// *** verif/scc_ref_gen.sv ***
// far-side reference source: one pulse of a given width per launch request
// assumes launch is a one-cycle level sampled on the rising clk edge
`timescale 1ns/1ps
`default_nettype none
module scc_ref_gen (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // request from the bench
  input  wire logic       launch,
  input  wire logic [3:0] width,
  // reference output
  output logic            refPin
);
  logic [3:0] left_ff;

  // the pin is driven low between pulses, never left floating
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      refPin  <= 1'b0;
      left_ff <= 4'h0;
    end else if (launch) begin
      refPin  <= 1'b1;
      left_ff <= width;
    end else if (left_ff != 4'h0) begin
      left_ff <= left_ff - 4'h1;
      refPin  <= (left_ff != 4'h1);
    end
  end
endmodule
`default_nettype wire

// *** verif/scc_capture_ctrl_bench.sv ***
// self-checking bench for the reference capture control block
// assumes scc_consts.svh on the include path and a zero-wait apb slave
`timescale 1ns/1ps
`default_nettype none
`include "scc_consts.svh"
module scc_capture_ctrl_bench;
  localparam int P = 8;
  localparam int B = 4 * P;
  localparam logic [31:0] A_CTRL = 32'(`SCC_IDX_CTRL) << 2;
  localparam logic [31:0] A_IGN  = 32'(`SCC_IDX_IGNORE) << 2;
  localparam logic [31:0] A_SKEW = 32'(`SCC_IDX_SKEW) << 2;
  localparam logic [31:0] A_STAT = 32'(`SCC_IDX_IRQ_STATUS) << 2;
  localparam logic [31:0] A_MASK = 32'(`SCC_IDX_IRQ_MASK) << 2;
  logic        clk     = 1'b0;
  logic        rst_n   = 1'b0;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [31:0] paddr   = 32'h0000_0000;
  logic [31:0] pwdata  = 32'h0000_0000;
  logic        launch  = 1'b0;
  logic [3:0]  width   = 4'h2;
  logic [3:0]  expStat = 4'h0;
  logic [31:0] prdata;
  logic        pready, pslverr, refPin, realign, setupErr, holdErr, irq;
  int          n_mismatch = 0;
  int          n_compared = 0;
  int          cyc = 0;
  int          last = 0;
  int          wprev = 2;
  int          ph, ts, es, mode, frst, neg, pos, ign, left, armed, quiet;
  bit          eS, eH;

  scc_capture_ctrl #(.PERIOD(P)) i_scc_capture_ctrl (
    .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .refPin(refPin),
    .realign(realign), .setupErr(setupErr), .holdErr(holdErr), .irq(irq));
  scc_ref_gen i_scc_ref_gen (.clk(clk), .rst_n(rst_n), .launch(launch),
    .width(width), .refPin(refPin));

  always #2.5 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;

  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic check(string s, logic [31:0] x, logic [31:0] got);
    n_compared++;
    if (got !== x) begin
      n_mismatch++;
      $display("Error %s expected %0h seen %0h", s, x, got);
    end
  endtask

  task automatic apb(logic w, logic [31:0] a, logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int k;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge clk);
      if (pready === 1'b1)
        break;
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k == 50)
      check("pready wait", 1'b1, 1'b0);
    if (k == 50)
      conclude();
    @(posedge clk);
  endtask

  task automatic wr(logic [31:0] a, logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rd(string s, logic [31:0] a, logic [31:0] x);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0000_0000, r, e);
    check(s, x, r);
  endtask

  function automatic bit inWin(int p);
    return p == 0 || (neg > 0 && p >= P - neg) || (p >= 1 && p <= pos);
  endfunction

  // capture is switched off before the transition select may change
  task automatic setCtrl(int f, int t, int e, int m);
    wr(A_CTRL, 32'(f * 64 + ts * 16 + es * 8));
    ts = t;
    es = e;
    mode = m;
    frst = f;
    wr(A_CTRL, 32'(f * 64 + t * 16 + e * 8 + m * 2));
    armed = (m == 2);
    left = ign;
    if (f) begin
      eS = 0;
      eH = 0;
    end
  endtask

  task automatic setWin(int n, int p);
    wr(A_SKEW, 32'(n * 4 + p));
    neg = n;
    pos = p;
  endtask

  // launches are scheduled d cycles apart, unless the bus traffic between takes longer
  task automatic pulse(int d, logic [3:0] w);
    int p, k, at, seen;
    bit go, hit;
    p = (ph + d + (ts ? int'(w) - wprev : 0)) % P;
    wprev = w;
    go = mode == 1 || (mode == 2 && armed && left == 0);
    if (mode == 2 && armed && left > 0)
      left--;
    else if (mode == 2 && go) begin
      armed = 0;
      expStat[3] = 1'b1;
    end
    hit = go && !inWin(p);
    if ((mode == 1 || mode == 2) && !inWin(p) && !frst) begin
      if (p >= P / 2)
        eS = 1;
      else
        eH = 1;
    end
    expStat[2:0] = expStat[2:0] | {eH, eS, hit};
    ph = hit ? 0 : p;
    for (k = 0; k < 300 && cyc < last + d; k++)
      @(posedge clk);
    if (k == 300)
      check("launch wait", 1'b1, 1'b0);
    width <= w;
    launch <= 1'b1;
    last = cyc;
    @(posedge clk);
    launch <= 1'b0;
    seen = 0;
    at = 0;
    for (k = 1; k < 12; k++) begin
      @(posedge clk);
      #1;
      if (realign === 1'b1) begin
        seen++;
        at = k;
      end
    end
    @(posedge clk);
    if (!quiet) begin
      check("realign count", hit, seen);
      if (hit && !es)
        check("realign latency", 4 + (ts ? w : 0), at);
      check("setup flag", eS, setupErr);
      check("hold flag", eH, holdErr);
    end
  endtask

  // the first pulse lands at an unknown phase; the second always realigns
  task automatic sync();
    quiet = 1;
    wprev = 2;
    pulse(B, 4'h2);
    pulse(B + 3, 4'h2);
    quiet = 0;
    ph = 0;
    setCtrl(1, ts, es, mode);
    setCtrl(0, ts, es, mode);
    wr(A_STAT, 32'h0000_000F);
    expStat = 4'h0;
  endtask

  task automatic regTest();
    logic [31:0] r;
    logic e;
    rd("ctrl reset", A_CTRL, 32'h0000_0000);
    rd("ignore reset", A_IGN, 32'h0000_0000);
    rd("skew reset", A_SKEW, 32'h0000_0000);
    wr(A_CTRL, 32'hFFFF_FFF9);
    rd("ctrl fields", A_CTRL, 32'h0000_0058);
    wr(A_CTRL, 32'h0000_0000);
    wr(A_IGN, 32'hFFFF_FFFF);
    rd("ignore field", A_IGN, 32'h0000_000F);
    wr(A_SKEW, 32'hFFFF_FFFF);
    rd("skew fields", A_SKEW, 32'h0000_000F);
    apb(1'b1, 32'h0000_0500, 32'h0000_00FF, r, e);
    check("unmapped error", 1'b1, e);
    apb(1'b0, 32'h0000_0500, 32'h0000_0000, r, e);
    check("unmapped data", 32'h0000_0000, r);
    wr(A_IGN, 32'h0000_0000);
    $display("register test done");
  endtask

  task automatic winTest();
    for (int i = 0; i < 4; i++) begin
      setWin(0, 0);
      setCtrl(0, 0, 0, 1);
      sync();
      setWin(i, i);
      pulse(B + i, 4'h2);
      pulse(B + 1, 4'h2);
      pulse(B - i, 4'h2);
      pulse(B - 1, 4'h2);
    end
    setCtrl(1, 0, 0, 1);
    check("setup flag held", 1'b0, setupErr);
    check("hold flag held", 1'b0, holdErr);
    pulse(B + 3, 4'h2);
    setCtrl(0, 0, 0, 0);
    pulse(B + 3, 4'h2);
    setCtrl(0, 0, 0, 3);
    pulse(B + 3, 4'h2);
    $display("window test done");
  endtask

  task automatic irqTest();
    setWin(0, 0);
    setCtrl(0, 0, 0, 1);
    sync();
    pulse(B + 2, 4'h2);
    rd("irq status", A_STAT, {28'h000_0000, expStat});
    wr(A_MASK, 32'h0000_0001);
    check("irq unmasked", 1'b1, irq);
    wr(A_MASK, 32'h0000_000A);
    check("irq masked", 1'b0, irq);
    wr(A_STAT, 32'h0000_000F);
    rd("irq status cleared", A_STAT, 32'h0000_0000);
    wr(A_MASK, 32'h0000_000F);
    check("irq idle", 1'b0, irq);
    wr(A_MASK, 32'h0000_0000);
    $display("interrupt test done");
  endtask

  // a wide pulse shifts the falling edge against the rising one
  task automatic edgeTest();
    setWin(0, 0);
    for (int c = 0; c < 4; c++) begin
      setCtrl(0, c / 2, c % 2, 1);
      sync();
      pulse(B, 4'h5);
      pulse(B + 2, 4'h2);
    end
    $display("edge test done");
  endtask

  task automatic oneTest();
    int n[3] = '{0, 1, 15};
    foreach (n[j]) begin
      setWin(0, 0);
      setCtrl(0, 0, 0, 1);
      sync();
      wr(A_IGN, 32'(n[j]));
      ign = n[j];
      setCtrl(0, 0, 0, 2);
      // spacing must exceed the bus traffic since the last sync pulse
      pulse(B + 9, 4'h2);
      for (int i = 0; i <= n[j]; i++)
        pulse(B + 3, 4'h2);
    end
    $display("one-shot test done");
  endtask

  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    regTest();
    winTest();
    irqTest();
    edgeTest();
    oneTest();
    conclude();
  end
endmodule
`default_nettype wire
